// file: logic/qdp_params.svh
// Constants of the quad digital pot register and control block
`ifndef QDP_PARAMS_SVH
`define QDP_PARAMS_SVH

`define QDP_NUM_CH          4
`define QDP_ADDR_LAST_CH    4'h3
`define QDP_ADDR_GP_LAST    4'h6
`define QDP_ADDR_RSVD       4'h7
`define QDP_ADDR_ACR        4'h8
`define QDP_NV_DEPTH        7
`define QDP_WIPER_PRESET    7'h40
`define QDP_ACR_VOL_BIT     7
`define QDP_ACR_SHUTDOWN_CONTROL_BIT    6
`define QDP_ACR_BUSY_BIT    5
`define QDP_VOL_RST         1'b0
`define QDP_SHUTDOWN_CONTROL_RST        1'b1
`define QDP_ID_PREFIX       4'hA
`define QDP_NV_WRITE_MS     20
`define QDP_CLK_KHZ         125000
`define QDP_PU_LOAD_CYCLES  8'h10

`endif

// file: logic/qdp_pkg.sv
// Types of the quad digital pot register and control block
package qdp_pkg;

  typedef enum logic [2:0] {
    QDP_IDLE, QDP_RX, QDP_ACK, QDP_TX, QDP_RACK
  } qdp_bus_state_t;

  typedef enum logic [1:0] {
    QDP_PH_ID, QDP_PH_ADDR, QDP_PH_DATA
  } qdp_phase_t;

  typedef enum logic [1:0] {
    QDP_PU_PRESET, QDP_PU_LOAD, QDP_PU_RUN
  } qdp_pu_t;

  typedef struct packed {
    qdp_bus_state_t  state;
    qdp_phase_t      phase;
    qdp_pu_t         pu;
    logic [7:0]      pu_cnt;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic            rw;
    logic            acked;
    logic [3:0]      ptr;
    logic            sda_oe;
    logic [3:0][6:0] wiper;
    logic            volatile_select;
    logic            shutdown_control_bit;
    logic            nv_pend;
    logic            scl_prev;
    logic            sda_prev;
    logic            pot_shutdown;
  } qdp_state_t;

  typedef struct packed {
    logic        busy;
    logic [31:0] cnt;
  } qdp_timer_t;

endpackage

// file: logic/qdp_sync.sv
// Two flip-flop synchroniser, one per input bit
`timescale 1ns/10ps
`default_nettype none

module qdp_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic stab_q;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RST_VAL[i];
          stab_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate

endmodule

`default_nettype wire

// file: logic/qdp_nv_timer.sv
// Self-timed non-volatile write cycle timer
`timescale 1ns/10ps
`default_nettype none

module qdp_nv_timer
  import qdp_pkg::*;
#(
  parameter int unsigned CYCLES = 2500000
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  output logic      busy
);

  qdp_timer_t q;
  qdp_timer_t d;

  always_comb begin
    d = q;
    if (q.busy) begin
      if (q.cnt == 32'h0000_0001) begin
        d.busy = 1'b0;
      end
      d.cnt = q.cnt - 32'h0000_0001;
    end else if (start) begin
      d.busy = 1'b1;
      d.cnt  = CYCLES;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;

endmodule

`default_nettype wire

// file: logic/qdp_core.sv
// Register bank, serial slave and shutdown control of a quad digital pot
`timescale 1ns/10ps
`default_nettype none
`include "qdp_params.svh"

module qdp_core
  import qdp_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = `QDP_NV_WRITE_MS * `QDP_CLK_KHZ
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps and shutdown pin
  input  wire logic [2:0] slave_addr_pins,
  input  wire logic       shutdown_n_pin,
  // Potentiometer side
  output logic      [6:0] wiper_terminal_ch0,
  output logic      [6:0] wiper_terminal_ch1,
  output logic      [6:0] wiper_terminal_ch2,
  output logic      [6:0] wiper_terminal_ch3,
  output logic            pot_shutdown,
  output logic            nv_write_busy
);

  qdp_state_t q;
  qdp_state_t d;
  logic [5:0] sync_s;
  logic       scl_s;
  logic       sda_s;
  logic       shutdown_control_s;
  logic [2:0] addr_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       busy;
  logic       nv_start;
  logic       nv_we;
  logic [7:0] rd_data;
  logic       wr_commit;
  logic       ptr_inc;
  logic [7:0] nv_mem [`QDP_NV_DEPTH];

  qdp_sync #(
    .W       (6),
    .RST_VAL (6'h3F)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({scl_in, sda_in, shutdown_n_pin, slave_addr_pins}),
    .sync_out (sync_s)
  );

  assign scl_s  = sync_s[5];
  assign sda_s  = sync_s[4];
  assign shutdown_control_s = sync_s[3];
  assign addr_s = sync_s[2:0];

  qdp_nv_timer #(
    .CYCLES (NV_WRITE_CYCLES)
  ) u_nv_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (nv_start),
    .busy    (busy)
  );

  assign scl_rise = scl_s & ~q.scl_prev;
  assign scl_fall = ~scl_s & q.scl_prev;
  assign start_c  = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
  assign stop_c   = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

  always_comb begin
    rd_data = 8'h00;
    if (q.ptr <= `QDP_ADDR_LAST_CH) begin
      rd_data = q.volatile_select ? {1'b0, q.wiper[q.ptr[1:0]]} : nv_mem[q.ptr[2:0]];
    end else if (q.ptr <= `QDP_ADDR_GP_LAST) begin
      rd_data = nv_mem[q.ptr[2:0]];
    end else if (q.ptr == `QDP_ADDR_ACR) begin
      rd_data[`QDP_ACR_VOL_BIT]  = q.volatile_select;
      rd_data[`QDP_ACR_SHUTDOWN_CONTROL_BIT] = q.shutdown_control_bit;
      rd_data[`QDP_ACR_BUSY_BIT] = busy;
    end
  end

  always_comb begin
    d          = q;
    nv_start   = 1'b0;
    nv_we      = 1'b0;
    wr_commit  = 1'b0;
    ptr_inc    = 1'b0;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    d.pot_shutdown = ~(shutdown_control_s & q.shutdown_control_bit);

    case (q.pu)
      // wipers hold preset until stores are readable
      QDP_PU_PRESET: begin
        d.pu_cnt = q.pu_cnt + 8'h01;
        if (q.pu_cnt == `QDP_PU_LOAD_CYCLES) begin
          d.pu = QDP_PU_LOAD;
        end
      end
      QDP_PU_LOAD: begin
        for (int i = 0; i < `QDP_NUM_CH; i++) begin
          d.wiper[i] = nv_mem[i][6:0];
        end
        d.pu = QDP_PU_RUN;
      end
      QDP_PU_RUN: begin
      end
      default: d.pu = QDP_PU_PRESET;
    endcase

    if (stop_c) begin
      d.state  = QDP_IDLE;
      d.sda_oe = 1'b0;
      if (q.nv_pend) begin
        nv_start  = 1'b1;
        d.nv_pend = 1'b0;
      end
    end else if (start_c && q.pu == QDP_PU_RUN) begin
      // Start is ignored during power-up
      d.state   = QDP_RX;
      d.phase   = QDP_PH_ID;
      d.bit_cnt = 4'h0;
      d.sda_oe  = 1'b0;
    end else begin
      case (q.state)
        QDP_IDLE: begin
        end
        QDP_RX: begin
          if (scl_rise) begin
            d.shreg   = {q.shreg[6:0], sda_s};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == 4'h8) begin
            d.bit_cnt = 4'h0;
            case (q.phase)
              QDP_PH_ID: begin
                if (q.shreg[7:1] == {`QDP_ID_PREFIX, addr_s}) begin
                  d.rw     = q.shreg[0];
                  d.state  = QDP_ACK;
                  d.sda_oe = 1'b1;
                end else begin
                  d.state = QDP_IDLE;
                end
              end
              QDP_PH_ADDR: begin
                d.ptr    = q.shreg[3:0];
                d.phase  = QDP_PH_DATA;
                d.state  = QDP_ACK;
                d.sda_oe = 1'b1;
              end
              default: begin
                wr_commit = 1'b1;
                ptr_inc   = 1'b1;
                d.state   = QDP_ACK;
                d.sda_oe  = 1'b1;
              end
            endcase
          end
        end
        QDP_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.state  = QDP_RX;
            if (q.phase == QDP_PH_ID && q.rw) begin
              d.state   = QDP_TX;
              d.shreg   = rd_data;
              d.sda_oe  = ~rd_data[7];
              d.bit_cnt = 4'h0;
            end else if (q.phase == QDP_PH_ID) begin
              d.phase = QDP_PH_ADDR;
            end
          end
        end
        QDP_TX: begin
          if (scl_fall) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == 4'h7) begin
              d.sda_oe = 1'b0;
              d.state  = QDP_RACK;
            end else begin
              d.shreg  = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
            end
          end
        end
        QDP_RACK: begin
          if (scl_rise) begin
            d.acked = ~sda_s;
            ptr_inc = 1'b1;
          end else if (scl_fall) begin
            if (q.acked) begin
              d.state   = QDP_TX;
              d.shreg   = rd_data;
              d.sda_oe  = ~rd_data[7];
              d.bit_cnt = 4'h0;
            end else begin
              d.state = QDP_IDLE;
            end
          end
        end
        default: d.state = QDP_IDLE;
      endcase
    end

    // writes ignored while busy; shutdown does not block them
    if (wr_commit && !busy) begin
      if (q.ptr <= `QDP_ADDR_LAST_CH) begin
        // channel select, routing, store also loads wiper
        d.wiper[q.ptr[1:0]] = q.shreg[6:0];
        if (!q.volatile_select) begin
          nv_we     = 1'b1;
          d.nv_pend = 1'b1;
        end
      end else if (q.ptr <= `QDP_ADDR_GP_LAST) begin
        nv_we     = 1'b1;
        d.nv_pend = 1'b1;
      end else if (q.ptr == `QDP_ADDR_ACR) begin
        d.volatile_select      = q.shreg[`QDP_ACR_VOL_BIT];
        d.shutdown_control_bit = q.shreg[`QDP_ACR_SHUTDOWN_CONTROL_BIT];
      end
    end

    if (ptr_inc) begin
      d.ptr = (q.ptr >= `QDP_ADDR_ACR) ? 4'h0 : q.ptr + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q              <= '0;
      q.state        <= QDP_IDLE;
      q.phase        <= QDP_PH_ID;
      q.pu           <= QDP_PU_PRESET;
      q.wiper        <= {`QDP_NUM_CH{`QDP_WIPER_PRESET}};
      q.volatile_select          <= `QDP_VOL_RST;
      q.shutdown_control_bit     <= `QDP_SHUTDOWN_CONTROL_RST;
      q.scl_prev     <= 1'b1;
      q.sda_prev     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // stores have no reset so that they model retention
  always_ff @(posedge sys_clk) begin
    if (nv_we) begin
      nv_mem[q.ptr[2:0]] <= q.shreg;
    end
  end

  // tap follows wiper; shutdown only via pot_shutdown
  assign wiper_terminal_ch0 = q.wiper[0];
  assign wiper_terminal_ch1 = q.wiper[1];
  assign wiper_terminal_ch2 = q.wiper[2];
  assign wiper_terminal_ch3 = q.wiper[3];
  assign pot_shutdown       = q.pot_shutdown;
  assign nv_write_busy      = busy;
  assign sda_out            = 1'b0;
  assign sda_oe             = q.sda_oe;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_nv_start;
    nv_start;
  endsequence

  sequence s_busy_hold;
    busy [*4];
  endsequence

  property p_preset;
    q.pu == QDP_PU_PRESET |-> q.wiper == {4{`QDP_WIPER_PRESET}};
  endproperty
  a_preset: assert property (p_preset)
    else $error("wiper not at preset during power-up");

  property p_vol_write;
    wr_commit && !busy && q.volatile_select && q.ptr <= 4'h3
      |=> q.wiper[$past(q.ptr[1:0])] == $past(q.shreg[6:0]);
  endproperty
  a_vol_write: assert property (p_vol_write)
    else $error("volatile wiper write lost");

  property p_store_copy;
    wr_commit && !busy && !q.volatile_select && q.ptr <= 4'h3
      |=> q.nv_pend && q.wiper[$past(q.ptr[1:0])] == $past(q.shreg[6:0]);
  endproperty
  a_store_copy: assert property (p_store_copy)
    else $error("store write did not load wiper");

  property p_shutdown;
    (!shutdown_control_s || !q.shutdown_control_bit) |=> pot_shutdown;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown not entered");

  property p_busy_block;
    busy && wr_commit && q.ptr == 4'h8 |=> $stable(q.volatile_select) && $stable(q.shutdown_control_bit);
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("access control changed while busy");

  property p_acr_low;
    q.ptr == 4'h8 |-> rd_data[4:0] == 5'h00 && rd_data[5] == busy;
  endproperty
  a_acr_low: assert property (p_acr_low)
    else $error("access control low bits or busy flag wrong");

  property p_rsvd;
    q.ptr == 4'h7 |-> rd_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved address not zero");

  property p_wrap;
    ptr_inc && q.ptr == 4'h8 |=> q.ptr == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap");

  property p_nv_busy;
    s_nv_start |=> s_busy_hold;
  endproperty
  a_nv_busy: assert property (p_nv_busy)
    else $error("write cycle busy too short");

  property p_hold_in_shutdown_control;
    pot_shutdown && !wr_commit && q.pu == QDP_PU_RUN |=> $stable(q.wiper);
  endproperty
  a_hold_in_shutdown_control: assert property (p_hold_in_shutdown_control)
    else $error("wiper changed by shutdown");

endmodule

`default_nettype wire

// file: dv/qdp_i2c_master.sv
// Serial bus master model facing the quad pot slave
`timescale 1ns/10ps
`default_nettype none

module qdp_i2c_master (
  // Bus lines, open drain with pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic [7:0] rx;
  event       got;

  // Idle bus: clock stands high, data released
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // change data while clock low
  // Data moves late in the low phase so the slave's synced clock is low
  task automatic bitx(input logic b, output logic r);
    #36 sda_drv = b;
    #4 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask

  task automatic start();
    #36 sda_drv = 1'b1;
    #4 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask

  task automatic stop();
    #36 sda_drv = 1'b0;
    #4 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) bitx(b[i], nak);
    bitx(1'b1, nak);
  endtask

  // acknowledge all but the last byte
  task automatic rbyte(input logic last);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(1'b1, rx[i]);
    -> got;
    bitx(last, a);
  endtask
endmodule

`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench of the quad pot register and control block
`timescale 1ns/10ps
`default_nettype none
`include "qdp_params.svh"

module testbench;
  localparam int NV = 2000;
  logic       sys_clk, rst_n, scl, sda_drv, sda_out, sda_oe;
  logic       sd_n, busy, shut, k;
  wire logic  sda;
  logic [2:0] pins;
  logic [6:0] w [4], sv [4];
  logic [7:0] v, exp_q[$], wd[$];
  int         seed = 46692, fail_count = 0, tests_run = 0, cyc = 0;

  // Wired-AND of master and slave on the pulled-up data line
  assign sda = sda_drv & ~(sda_oe & ~sda_out);

  qdp_core #(.NV_WRITE_CYCLES(NV)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_pins(pins),
    .shutdown_n_pin(sd_n), .wiper_terminal_ch0(w[0]),
    .wiper_terminal_ch1(w[1]), .wiper_terminal_ch2(w[2]),
    .wiper_terminal_ch3(w[3]), .pot_shutdown(shut),
    .nv_write_busy(busy));
  qdp_i2c_master m (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Read bytes are judged against the oldest expectation
  always @(m.got) chk(m.rx, exp_q.pop_front());

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic sendb(input logic [7:0] b);
    m.wbyte(b, k);
    chk({7'h00, k}, 8'h00);
  endtask

  task automatic wr(input logic [3:0] a);
    m.start();
    sendb({`QDP_ID_PREFIX, pins, 1'b0});
    sendb({4'h0, a});
    foreach (wd[i]) sendb(wd[i]);
    m.stop();
    tick(8);
  endtask

  task automatic w1(input logic [3:0] a, input logic [7:0] d);
    wd = '{d};
    wr(a);
  endtask

  task automatic rd(input logic [3:0] a, input int n);
    m.start();
    sendb({`QDP_ID_PREFIX, pins, 1'b0});
    sendb({4'h0, a});
    m.start();
    sendb({`QDP_ID_PREFIX, pins, 1'b1});
    for (int i = 1; i <= n; i++) m.rbyte(i == n);
    m.stop();
    tick(8);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(2);
    foreach (w[i]) chk({1'b0, w[i]}, 8'h40);
    tick(30);
  endtask

  initial begin
    sd_n = 1'b1;
    pins = 3'($random(seed));
    do_reset();
    exp_q.push_back(8'h40);
    rd(4'h8, 1);
    $display("test reset values done");
    w1(4'h8, 8'hC0);
    wd.delete();
    repeat (4) wd.push_back({1'b0, 7'($random(seed))});
    wr(4'h0);
    foreach (w[i]) chk({1'b0, w[i]}, wd[i]);
    exp_q = {8'h00, 8'hC0, wd};
    w1(4'h7, 8'h55);
    rd(4'h7, 6);
    $display("test wiper access done");
    sv = w;
    for (int i = 0; i < 4; i++) begin
      sd_n = i[0];
      w1(4'h8, {1'b1, i[1], 6'h00});
      chk({7'h00, shut}, {7'h00, ~(i[0] & i[1])});
      foreach (w[j]) chk({1'b0, w[j]}, {1'b0, sv[j]});
      exp_q.push_back({1'b1, i[1], 6'h00});
      rd(4'h8, 1);
    end
    $display("test shutdown done");
    w1(4'h8, 8'h40);
    v = {1'b0, 7'($random(seed))};
    w1(4'h1, v);
    chk({7'h00, busy}, 8'h01);
    chk({1'b0, w[1]}, v);
    exp_q.push_back(8'h60);
    rd(4'h8, 1);
    w1(4'h8, 8'hC0);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
    chk({7'h00, busy}, 8'h00);
    exp_q.push_back(8'h40);
    rd(4'h8, 1);
    exp_q.push_back(v);
    rd(4'h1, 1);
    do_reset();
    chk({1'b0, w[1]}, v);
    $display("test store and busy done");
    m.start();
    m.wbyte({`QDP_ID_PREFIX, ~pins, 1'b0}, k);
    m.stop();
    chk({7'h00, k}, 8'h01);
    $display("test slave address done");
    results();
  end
endmodule

`default_nettype wire
